// ==== design/hub_port_strap_and_power_pins.sv ====
`timescale 1ns/1ps
// Function
// - Names ending in _n or _low are active low, others active high.
// - Upstream pull-up is enabled only while upstream supply is present.
// - With port-off straps enabled, data pins sampled at reset release.
// - One supply enable output per downstream port powers its peripheral.
// - With charge straps enabled, supply enable pins sampled at reset release.
// - Charging ports also work with an external port power controller.
// - Active-low overcurrent input per port flags an overcurrent condition.
// - Method select pins latched on reset release choose the strap options.
module hub_port_strap_and_power_pins
  import hub_strap_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic config_method_select_0,
  input wire logic config_method_select_1,
  input wire logic upstream_supply_detect,
  output logic upstream_pullup_enable,
  input wire logic [PORT_COUNT-1:0] downstream_data_plus,
  input wire logic [PORT_COUNT-1:0] downstream_data_minus,
  input wire logic [PORT_COUNT-1:0] port_supply_enable_in,
  output logic [PORT_COUNT-1:0] port_supply_enable,
  output logic [PORT_COUNT-1:0] port_supply_enable_oe_n,
  input wire logic [PORT_COUNT-1:0] overcurrent_sense_low,
  output logic [PORT_COUNT-1:0] port_overcurrent,
  output logic [PORT_COUNT-1:0] port_disabled,
  output logic [PORT_COUNT-1:0] port_charge_support
);

  load_state_t load_state;
  load_state_t next_load_state;
  strap_image_t straps;
  ahb_phase_t phase;
  logic [3:0] ctrl_power;
  logic supply_level;
  logic [1:0] method_latched;
  logic [3:0] off_latched;
  logic [3:0] charge_latched;

  // Loader decodes; the latches capture on the single sample cycle.
  wire sample_pulse = (load_state == LOAD_SAMPLE);
  wire running = (load_state == LOAD_RUN);
  // Method pins are read as a two-bit code, select 1 being the upper bit.
  wire [1:0] method_pins = {config_method_select_1, config_method_select_0};

  // Which strap kinds the selected method honours.
  wire off_straps_on = (method_latched == METHOD_STRAPS) ||
                       (method_latched == METHOD_DEFAULT);
  wire charge_straps_on = (method_latched == METHOD_STRAPS);

  // The port-off strap needs both data pins high in the same sample.
  wire [3:0] off_pins = downstream_data_plus & downstream_data_minus;

  // Strap decisions gated by the method that was in force at release.
  wire [3:0] off_effective = off_straps_on ? off_latched : 4'h0;
  wire [3:0] charge_effective = charge_straps_on ? charge_latched : 4'h0;

  // Overcurrent asserts when the low-active sense pin is low.
  wire [3:0] overcurrent_now = ~overcurrent_sense_low;

  // Port power is software's request, minus disabled and overloaded ports.
  wire [3:0] next_power = ctrl_power & ~off_effective & ~overcurrent_now;

  // Loader walks reset, one sample cycle, then normal running.
  // The extra cycle leaves the strap pins undriven for a whole cycle before they are read.
  always_comb
  begin
    case (load_state)
      LOAD_IN_RESET: next_load_state = LOAD_SAMPLE;
      LOAD_SAMPLE: next_load_state = LOAD_RUN;
      LOAD_RUN: next_load_state = LOAD_RUN;
      default: next_load_state = LOAD_IN_RESET;
    endcase
  end

  // Loader state register; reset returns it to the strap-reading sequence.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      load_state <= LOAD_IN_RESET;
    end
    else
    begin
      load_state <= next_load_state;
    end
  end

  strap_latch #(.WIDTH(2)) method_latch (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(sample_pulse),
    .pins(method_pins),
    .value(method_latched)
  );

  strap_latch #(.WIDTH(4)) off_latch (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(sample_pulse),
    .pins(off_pins),
    .value(off_latched)
  );

  strap_latch #(.WIDTH(4)) charge_latch (
    .clk(clk),
    .sys_rst(sys_rst),
    .capture(sample_pulse),
    .pins(port_supply_enable_in),
    .value(charge_latched)
  );

  // The supply detect line comes from a divider on a cable and may bounce.
  // Two agreeing samples cost three cycles of delay but keep a bounce from toggling connect.
  level_filter supply_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw(upstream_supply_detect),
    .level(supply_level)
  );

  // Latched image as shown to software and to the pin drivers.
  always_comb
  begin
    straps.method = method_latched;
    straps.charge = charge_effective;
    straps.port_off = off_effective;
  end

  // Next values of the pin drivers; each stays at its idle level until running.
  // pull-up follows supply
  wire next_pullup = running & supply_level;
  wire [3:0] next_supply_enable = running ? next_power : 4'h0;
  wire [3:0] next_supply_oe_n = running ? 4'h0 : 4'hF;
  wire [3:0] next_overcurrent = running ? overcurrent_now : 4'h0;
  // Strap results are only shown once the loader has finished sampling.
  wire [3:0] next_disabled = running ? straps.port_off : 4'h0;
  wire [3:0] next_charge = running ? straps.charge : 4'h0;

  // Connect pull-up; off in reset so the host sees no connect before straps settle.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      upstream_pullup_enable <= 1'b0;
    end
    else
    begin
      upstream_pullup_enable <= next_pullup;
    end
  end

  // Supply enables; the pins stay undriven while the charge straps are read.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_supply_enable <= 4'h0;
      port_supply_enable_oe_n <= 4'hF;
    end
    else
    begin
      port_supply_enable <= next_supply_enable;
      port_supply_enable_oe_n <= next_supply_oe_n;
    end
  end

  // Overcurrent flag follows the sense pins one cycle late; it is not sticky.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_overcurrent <= 4'h0;
    end
    else
    begin
      port_overcurrent <= next_overcurrent;
    end
  end

  // Strap results; constant from the second running cycle until the next reset.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_disabled <= 4'h0;
      port_charge_support <= 4'h0;
    end
    else
    begin
      port_disabled <= next_disabled;
      port_charge_support <= next_charge;
    end
  end

  // AHB-Lite address phase capture; the slave is always ready, zero waits.
  // Only the address phase is kept; a write uses it one cycle later with hwdata.
  wire take = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire write_ctrl = phase.valid & phase.write & (phase.offset == CTRL_OFFSET);
  wire [7:0] rd_offset = {haddr[7:2], 2'b00};

  // Address phase register, updated on every cycle the bus is ready.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase <= '0;
    end
    else if (hready)
    begin
      phase.valid <= take;
      phase.write <= hwrite;
      phase.offset <= {haddr[7:2], 2'b00};
    end
  end

  // Software power request; ignored for disabled ports downstream.
  // Writes land at the end of the data phase, while hwdata stands.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_power <= CTRL_POWER_RESET;
    end
    else if (write_ctrl)
    begin
      ctrl_power <= hwdata[CTRL_POWER_LSB +: 4];
    end
  end

  // Read mux; unmapped offsets read zero with OKAY.
  // Control is the first word, the strap image the second and status the third.
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (rd_offset)
      CTRL_OFFSET: next_rdata[CTRL_POWER_LSB +: 4] = ctrl_power;
      STRAP_OFFSET:
      begin
        next_rdata[STRAP_OFF_LSB +: 4] = straps.port_off;
        next_rdata[STRAP_CHARGE_LSB +: 4] = straps.charge;
        next_rdata[STRAP_METHOD_LSB +: 2] = straps.method;
      end
      STATUS_OFFSET:
      begin
        next_rdata[STATUS_OVERCURRENT_LSB +: 4] = port_overcurrent;
        next_rdata[STATUS_SUPPLY_BIT] = supply_level;
        next_rdata[STATUS_PULLUP_BIT] = upstream_pullup_enable;
        next_rdata[STATUS_OFF_LSB +: 4] = port_supply_enable;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // A read is taken in its address phase.
  wire take_read = take & ~hwrite;

  // Read data is registered at the address phase so it stands in the data phase.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (take_read)
    begin
      hrdata <= next_rdata;
    end
  end

  // The slave never stretches a transfer and never reports an error.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : hub_port_strap_and_power_pins

// ==== design/hub_strap_pkg.sv ====
package hub_strap_pkg;

  // Number of downstream ports handled by this block.
  localparam int unsigned PORT_COUNT = 4;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STRAP_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // Field positions inside the control register.
  localparam int unsigned CTRL_POWER_LSB = 0;
  // Field positions inside the strap register.
  localparam int unsigned STRAP_OFF_LSB = 0;
  localparam int unsigned STRAP_CHARGE_LSB = 4;
  localparam int unsigned STRAP_METHOD_LSB = 8;
  // Field positions inside the status register.
  localparam int unsigned STATUS_OVERCURRENT_LSB = 0;
  localparam int unsigned STATUS_SUPPLY_BIT = 4;
  localparam int unsigned STATUS_PULLUP_BIT = 5;
  localparam int unsigned STATUS_OFF_LSB = 8;

  // Reset values.
  localparam logic [3:0] CTRL_POWER_RESET = 4'h0;

  // Configuration method codes that enable each strap kind.
  localparam logic [1:0] METHOD_DEFAULT = 2'h0;
  localparam logic [1:0] METHOD_STRAPS = 2'h1;
  localparam logic [1:0] METHOD_SERIAL = 2'h2;
  localparam logic [1:0] METHOD_SMBUS = 2'h3;

  // Timing: minimum reset pulse, expressed at the 10 MHz clock.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RESET_MIN_US = 1;
  localparam int unsigned RESET_MIN_CYCLES =
    (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILTER_CYCLES = 2;

  // AHB transfer types.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Latched strap image.
  typedef struct packed {
    logic [1:0] method;
    logic [3:0] charge;
    logic [3:0] port_off;
  } strap_image_t;

  // Registered AHB address phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
  } ahb_phase_t;

  // Loader sequence states.
  typedef enum logic [1:0] {
    LOAD_IN_RESET = 2'b00,
    LOAD_SAMPLE = 2'b01,
    LOAD_RUN = 2'b10
  } load_state_t;

endpackage : hub_strap_pkg

// ==== design/strap_latch.sv ====
`timescale 1ns/1ps
module strap_latch
  import hub_strap_pkg::*;
#(
  parameter int unsigned WIDTH = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic capture,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] value
);

  // Holds the pin levels taken on the capture pulse until the next reset.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      value <= '0;
    end
    else if (capture)
    begin
      value <= pins;
    end
  end

endmodule : strap_latch

// ==== design/level_filter.sv ====
`timescale 1ns/1ps
module level_filter
  import hub_strap_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic raw,
  output logic level
);

  logic [1:0] history;

  // A level passes only once stable for two samples, rejecting single glitches.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      history <= 2'h0;
      level <= 1'b0;
    end
    else
    begin
      history <= {history[0], raw};
      if (history[1] == history[0])
      begin
        level <= history[1];
      end
    end
  end

endmodule : level_filter

// ==== sim/strap_pins_checker.sv ====
`timescale 1ns/1ps
module strap_pins_checker
  import hub_strap_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic config_method_select_0,
  input wire logic config_method_select_1,
  input wire logic upstream_supply_detect,
  input wire logic upstream_pullup_enable,
  input wire logic [PORT_COUNT-1:0] downstream_data_plus,
  input wire logic [PORT_COUNT-1:0] downstream_data_minus,
  input wire logic [PORT_COUNT-1:0] port_supply_enable_in,
  input wire logic [PORT_COUNT-1:0] port_supply_enable,
  input wire logic [PORT_COUNT-1:0] port_supply_enable_oe_n,
  input wire logic [PORT_COUNT-1:0] overcurrent_sense_low,
  input wire logic [PORT_COUNT-1:0] port_overcurrent,
  input wire logic [PORT_COUNT-1:0] port_disabled,
  input wire logic [PORT_COUNT-1:0] port_charge_support
);
  // One clock domain; reset masks every attempt.
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // The supply filter takes a few samples, so the windows allow for it.
  pullup_on_a: assert property (upstream_supply_detect [*6] |-> upstream_pullup_enable)
    else $error("pull-up missing with supply present");
  pullup_off_a: assert property (!upstream_supply_detect [*5] |-> !upstream_pullup_enable)
    else $error("pull-up on without supply");
  oc_follow_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |->
    port_overcurrent == ~$past(overcurrent_sense_low)) else $error("overcurrent flag wrong");
  power_oc_a: assert property ((port_supply_enable & ~$past(overcurrent_sense_low)
    & ~$past(overcurrent_sense_low, 2)) == 4'h0) else $error("power on during overcurrent");
  power_off_a: assert property ((port_supply_enable & port_disabled) == 4'h0)
    else $error("power on a disabled port");
  straps_hold_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    && !$past(sys_rst, 4) |-> $stable(port_disabled) && $stable(port_charge_support))
    else $error("strap moved");
  pin_release_a: assert property ($fell(sys_rst) |-> port_supply_enable_oe_n == 4'hF
    ##1 port_supply_enable_oe_n == 4'hF ##[1:2] port_supply_enable_oe_n == 4'h0)
    else $error("supply pin release wrong");
  off_strap_a: assert property ($fell(sys_rst) ##1 1 |-> ##2 port_disabled ==
    ($past(downstream_data_plus, 2) & $past(downstream_data_minus, 2)
    & {PORT_COUNT{!$past(config_method_select_1, 2)}})) else $error("port-off strap wrong");
  charge_strap_a: assert property ($fell(sys_rst) ##1 1 |-> ##2 port_charge_support ==
    ($past(port_supply_enable_in, 2)
    & {PORT_COUNT{$past(config_method_select_0, 2) && !$past(config_method_select_1, 2)}}))
    else $error("charge strap wrong");
endmodule : strap_pins_checker

bind hub_port_strap_and_power_pins strap_pins_checker chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .config_method_select_0(config_method_select_0),
  .config_method_select_1(config_method_select_1),
  .upstream_supply_detect(upstream_supply_detect),
  .upstream_pullup_enable(upstream_pullup_enable),
  .downstream_data_plus(downstream_data_plus),
  .downstream_data_minus(downstream_data_minus),
  .port_supply_enable_in(port_supply_enable_in),
  .port_supply_enable(port_supply_enable),
  .port_supply_enable_oe_n(port_supply_enable_oe_n),
  .overcurrent_sense_low(overcurrent_sense_low),
  .port_overcurrent(port_overcurrent),
  .port_disabled(port_disabled),
  .port_charge_support(port_charge_support)
);

// ==== sim/port_far_side.sv ====
`timescale 1ns/1ps
module port_far_side
  import hub_strap_pkg::*;
(
  input wire logic [PORT_COUNT-1:0] port_supply_enable,
  input wire logic [PORT_COUNT-1:0] port_supply_enable_oe_n,
  input wire logic [PORT_COUNT-1:0] off_straps,
  input wire logic [PORT_COUNT-1:0] charge_straps,
  input wire logic [PORT_COUNT-1:0] overloaded,
  output logic [PORT_COUNT-1:0] downstream_data_plus,
  output logic [PORT_COUNT-1:0] downstream_data_minus,
  output logic [PORT_COUNT-1:0] port_supply_enable_in,
  output logic [PORT_COUNT-1:0] overcurrent_sense_low
);
  // both lines pulled
  // A port-off strap pulls both lines up; otherwise the pull-downs win.
  assign downstream_data_plus = off_straps;
  assign downstream_data_minus = off_straps;
  // shared supply pin
  // The switch pin shows the device while driven, else its strap resistor.
  assign port_supply_enable_in = (port_supply_enable & ~port_supply_enable_oe_n)
    | (charge_straps & port_supply_enable_oe_n);
  // current monitor
  // The monitor pulls low on overload; the pull-up holds it high otherwise.
  assign overcurrent_sense_low = ~overloaded;
endmodule : port_far_side

// ==== sim/hub_port_strap_and_power_pins_bench.sv ====
`timescale 1ns/1ps
module hub_port_strap_and_power_pins_bench;
  import hub_strap_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
  logic config_method_select_0 = 1'b0, config_method_select_1 = 1'b0;
  logic upstream_supply_detect = 1'b1, hreadyout, hresp, upstream_pullup_enable;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h000183C4;
  logic [PORT_COUNT-1:0] off_straps = 4'h0, charge_straps = 4'h0, overloaded = 4'h0;
  logic [PORT_COUNT-1:0] downstream_data_plus, downstream_data_minus, port_supply_enable_in;
  logic [PORT_COUNT-1:0] port_supply_enable, port_supply_enable_oe_n, overcurrent_sense_low;
  logic [PORT_COUNT-1:0] port_overcurrent, port_disabled, port_charge_support, eo, ec, pw;
  logic [31:0] exp_q[$];
  int err_count = 0, samples_checked = 0, cycles = 0;
  wire hready = hreadyout;

  hub_port_strap_and_power_pins uut (.*);
  port_far_side far (.*);

  // Free-running 10 MHz clock.
  initial forever #50 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict;
    $display("compared %0d mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Single word transfer; for a read, d is the value the monitor expects.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (!hreadyout);
  endtask : bus

  // Board straps are drawn at random and held across the whole reset.
  task automatic restart(input logic [1:0] m);
    @(posedge clk);
    sys_rst <= 1'b1;
    config_method_select_0 <= m[0];
    config_method_select_1 <= m[1];
    repeat (8) seed = lfsr(seed);
    off_straps <= seed[3:0];
    charge_straps <= seed[7:4];
    eo = (m < 2'h2) ? seed[3:0] : 4'h0;
    ec = (m == 2'h1) ? seed[7:4] : 4'h0;
    repeat (RESET_MIN_CYCLES) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : restart

  // Read data is taken in the data phase that follows a taken read.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rd_pend)
    begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
    rd_pend <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    if (cycles == 1000)
    begin
      err_count++;
      give_verdict();
    end
  end

  // Every method code, then a supply drop and return.
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      restart(m[1:0]);
      off_straps <= ~off_straps;
      charge_straps <= ~charge_straps;
      overloaded <= seed[11:8];
      pw = 4'hF & ~eo & ~seed[11:8];
      #1;
      check({28'h0, port_disabled}, {28'h0, eo});
      check({28'h0, port_charge_support}, {28'h0, ec});
      check({28'h0, port_supply_enable_oe_n}, 32'h0);
      bus(1'b0, STRAP_OFFSET, {22'h0, m[1:0], ec, eo});
      bus(1'b0, CTRL_OFFSET, 32'h0);
      bus(1'b1, CTRL_OFFSET, 32'hF);
      bus(1'b0, 8'h0C, 32'h0);
      bus(1'b0, STATUS_OFFSET, {20'h0, pw, 4'h3, seed[11:8]});
      bus(1'b0, CTRL_OFFSET, 32'hF);
      #1;
      check({28'h0, port_supply_enable}, {28'h0, pw});
      check({28'h0, port_overcurrent}, {28'h0, seed[11:8]});
      $display("method %0d done", m);
    end
    @(posedge clk);
    upstream_supply_detect <= 1'b0;
    repeat (8) @(posedge clk);
    #1 check({31'h0, upstream_pullup_enable}, 32'h0);
    @(posedge clk);
    upstream_supply_detect <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check({31'h0, upstream_pullup_enable}, 32'h1);
    $display("supply test done");
    give_verdict();
  end
endmodule : hub_port_strap_and_power_pins_bench
